// ==== rtl/msp_defines.vh ====
`ifndef MSP_DEFINES_VH
`define MSP_DEFINES_VH

// counter and bus widths
`define MSP_CNT_W 16
`define MSP_ADR_W 8
`define MSP_DAT_W 32
`define MSP_CH_W 3

// register byte offsets
`define MSP_ADR_CTRL 8'h00
`define MSP_ADR_TRIG 8'h04
`define MSP_ADR_MRELOAD 8'h08
`define MSP_ADR_SRELOAD 8'h0C
`define MSP_ADR_MCOUNT 8'h10
`define MSP_ADR_SCOUNT 8'h14
`define MSP_ADR_STATUS 8'h18

// control register fields
`define MSP_CTRL_UNIT_EN 0
`define MSP_CTRL_PWM 1
`define MSP_CTRL_OUT_EN 2
`define MSP_CTRL_OUT_BIT 3
`define MSP_CTRL_OUT_LVL 4
`define MSP_CTRL_PIN_EN 5
`define MSP_CTRL_MCH_LO 8
`define MSP_CTRL_MCH_HI 10
`define MSP_CTRL_SCH_LO 12
`define MSP_CTRL_SCH_HI 14

// trigger register fields
`define MSP_TRIG_MSTART 0
`define MSP_TRIG_SSTART 1
`define MSP_TRIG_MSTOP 2
`define MSP_TRIG_SSTOP 3

// status register fields
`define MSP_STAT_MEN 0
`define MSP_STAT_SEN 1
`define MSP_STAT_MRUN 2
`define MSP_STAT_SRUN 3
`define MSP_STAT_OUT 4
`define MSP_STAT_PORT 5

// reset values
`define MSP_CNT_ZERO 16'h0000
`define MSP_CNT_ONE 16'h0001
`define MSP_RELOAD_RST 16'h0000
`define MSP_CH_MASTER_RST 3'h0
`define MSP_CH_SLAVE_RST 3'h1
`define MSP_DAT_ZERO 32'h00000000

`endif

// ==== rtl/msp_sync.v ====
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser with a registered rising-edge pulse
module msp_sync (
    input wire clk_i,
    input wire rst_i,
    input wire pin_i,
    output reg level_o,
    output reg rise_o
);
    reg meta;
    reg level_d;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            level_o <= 1'b0;
            level_d <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta <= pin_i;
            level_o <= meta;
            // only the second stage feeds logic, the first may still be settling
            level_d <= level_o;
            rise_o <= level_o & ~level_d;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/msp_chan.v ====
`timescale 1ns/100ps
`include "msp_defines.vh"
`default_nettype none
// one down-counting channel in one-count mode, optional self reload
module msp_chan (
    input wire clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire start_i,
    input wire stop_i,
    input wire auto_i,
    input wire [`MSP_CNT_W-1:0] reload_i,
    output reg [`MSP_CNT_W-1:0] cnt_o,
    output reg run_o,
    output reg done_o,
    output reg [`MSP_CNT_W-1:0] next_cnt_o,
    output reg next_run_o
);
    always @* begin
        next_cnt_o = cnt_o;
        next_run_o = run_o;
        done_o = 1'b0;
        if (clr_i) begin
            next_cnt_o = `MSP_CNT_ZERO;
            next_run_o = 1'b0;
        end else if (stop_i) begin
            // counter freezes at its present value
            next_run_o = 1'b0;
        end else if (start_i) begin
            next_cnt_o = reload_i; // see R3 see R5
            next_run_o = 1'b1;
            done_o = auto_i; // see R13
        end else if (run_o) begin
            if (cnt_o == `MSP_CNT_ZERO) begin
                done_o = 1'b1; // see R4 see R6 see R14
                if (auto_i) begin
                    next_cnt_o = reload_i; // see R14
                end else begin
                    next_run_o = 1'b0; // see R4 see R6
                end
            end else begin
                next_cnt_o = cnt_o - `MSP_CNT_ONE;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_o <= `MSP_CNT_ZERO;
            run_o <= 1'b0;
        end else begin
            cnt_o <= next_cnt_o;
            run_o <= next_run_o;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/msp_top.v ====
// What this block does
// R1: one-shot delay from trigger to pulse start is master reload plus two clocks.
// R2: pulse width equals the slave reload value in count clocks.
// R3: master loads its reload on a start trigger, then counts down each clock.
// R4: one-shot master at zero raises its done pulse and waits for the next trigger.
// R5: slave starts on the master done pulse, loads its reload and counts down.
// R6: slave at zero raises its own done pulse and stops until the next master pulse.
// R7: output goes active one clock after master done, inactive when slave hits zero.
// R8: a software write of the master start bit also starts a one-shot pulse.
// R9: software rewrites reloads only after the matching done pulse.
// R10: master channel is even 0 to 6; slave is a higher channel up to 7.
// R11: the master start bit sets both enable flags, the slave start bit only the slave flag; trigger bits read back as zero.
// R12: software sets the output enable before a start only when resuming.
// R13: in PWM the master raises done as it begins, which also starts the slave.
// R14: in PWM the master at zero raises done, reloads at once and keeps counting.
// R15: in PWM software changes only reloads, and only after a master done pulse.
// R16: both counters are readable at any time; no channel status is used.
// R17: stop bits clear enable flags, freeze both counters and hold the output.
// R18: with output enable clear, the pin drives the level software wrote.
// R19: clearing the unit enable resets everything, output bit zero, pin to port mode.
// R20: output active high when output level is zero, active low when one.
`timescale 1ns/100ps
`include "msp_defines.vh"
`default_nettype none
module msp_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`MSP_ADR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [`MSP_DAT_W-1:0] dat_i,
    output reg [`MSP_DAT_W-1:0] dat_o,
    output reg ack_o,
    input wire trigger_input_pin_i,
    output reg pulse_output_o,
    output reg port_mode_o,
    output reg master_done_irq_o,
    output reg slave_done_irq_o
);
    // control state
    reg unit_en;
    reg pwm_mode;
    reg slave_output_enable;
    reg slave_output_level;
    reg pin_trig_en;
    reg [`MSP_CH_W-1:0] master_ch;
    reg [`MSP_CH_W-1:0] slave_ch;
    reg [`MSP_CNT_W-1:0] master_reload_value;
    reg [`MSP_CNT_W-1:0] slave_reload_value;
    reg master_enabled_flag;
    reg slave_enabled_flag;
    reg out_bit;

    // bus decode
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire [`MSP_DAT_W-1:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [`MSP_DAT_W-1:0] wdat = dat_i & wmask;
    // writes other than control are dropped while the unit is off
    reg wr_ctrl;
    reg wr_trig;
    reg wr_mrel;
    reg wr_srel;
    always @* begin
        wr_ctrl = 1'b0;
        wr_trig = 1'b0;
        wr_mrel = 1'b0;
        wr_srel = 1'b0;
        if (wr) begin
            case (adr_i)
                `MSP_ADR_CTRL: wr_ctrl = 1'b1;
                `MSP_ADR_TRIG: wr_trig = unit_en;
                `MSP_ADR_MRELOAD: wr_mrel = unit_en;
                `MSP_ADR_SRELOAD: wr_srel = unit_en;
                default: wr_ctrl = 1'b0;
            endcase
        end
    end

    // control word as it stands, for read-modify under byte enables
    wire [`MSP_DAT_W-1:0] ctrl_word;
    assign ctrl_word = {17'h00000, slave_ch, 1'b0, master_ch, 2'h0, pin_trig_en, slave_output_level,
                        out_bit, slave_output_enable, pwm_mode, unit_en};
    wire [`MSP_DAT_W-1:0] ctrl_new = (ctrl_word & ~wmask) | wdat;
    wire [`MSP_DAT_W-1:0] mrel_new = ({16'h0000, master_reload_value} & ~wmask) | wdat;
    wire [`MSP_DAT_W-1:0] srel_new = ({16'h0000, slave_reload_value} & ~wmask) | wdat;

    // a write that clears the unit enable resets the unit in the same edge
    wire unit_clr = ~unit_en | (wr_ctrl & ~ctrl_new[`MSP_CTRL_UNIT_EN]);

    // master even, slave strictly above it
    reg pair_ok;
    always @* begin
        pair_ok = 1'b0;
        if (~master_ch[0]) begin
            pair_ok = (slave_ch > master_ch); // see R10
        end
    end

    // trigger bits are pulses only, nothing stores them
    wire sw_start = wr_trig & wdat[`MSP_TRIG_MSTART] & pair_ok; // see R8 see R11
    wire sw_sstart = wr_trig & wdat[`MSP_TRIG_SSTART] & pair_ok; // see R11
    wire sw_stop = wr_trig & (wdat[`MSP_TRIG_MSTOP] | wdat[`MSP_TRIG_SSTOP]); // see R17

    // external trigger
    wire pin_level;
    wire pin_rise;
    msp_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(trigger_input_pin_i),
        .level_o(pin_level),
        .rise_o(pin_rise)
    );

    wire pin_start = pin_rise & pin_trig_en & ~pwm_mode & master_enabled_flag & pair_ok;
    wire m_start = ~sw_stop & (sw_start | pin_start); // see R3 see R8

    // master channel
    wire [`MSP_CNT_W-1:0] master_counter;
    wire m_run;
    wire m_done;
    wire [`MSP_CNT_W-1:0] m_next_cnt;
    wire m_next_run;
    msp_chan u_master (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(unit_clr),
        .start_i(m_start),
        .stop_i(sw_stop),
        .auto_i(pwm_mode),
        .reload_i(master_reload_value),
        .cnt_o(master_counter),
        .run_o(m_run),
        .done_o(m_done),
        .next_cnt_o(m_next_cnt),
        .next_run_o(m_next_run)
    );

    // slave channel, started by the master done pulse
    wire s_armed = slave_enabled_flag | sw_sstart | sw_start;
    wire s_start = m_done & s_armed & ~sw_stop; // see R5 see R13
    wire [`MSP_CNT_W-1:0] slave_counter;
    wire s_run;
    wire s_done;
    wire [`MSP_CNT_W-1:0] s_next_cnt;
    wire s_next_run;
    msp_chan u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(unit_clr),
        .start_i(s_start),
        .stop_i(sw_stop),
        .auto_i(1'b0),
        .reload_i(slave_reload_value),
        .cnt_o(slave_counter),
        .run_o(s_run),
        .done_o(s_done),
        .next_cnt_o(s_next_cnt),
        .next_run_o(s_next_run)
    );

    // active while the slave holds a nonzero count
    wire tmr_active = s_next_run & (s_next_cnt != `MSP_CNT_ZERO); // see R2 see R7
    wire tmr_level = tmr_active ^ slave_output_level; // see R20
    wire tmr_owns = slave_output_enable & ~sw_stop & (s_start | s_run); // see R17

    reg next_out_bit;
    always @* begin
        next_out_bit = out_bit;
        if (unit_clr) begin
            next_out_bit = 1'b0; // see R19
        end else if (tmr_owns) begin
            next_out_bit = tmr_level; // see R1 see R7
        end else if (wr_ctrl & ~ctrl_new[`MSP_CTRL_OUT_EN]) begin
            next_out_bit = ctrl_new[`MSP_CTRL_OUT_BIT]; // see R18
        end
    end

    // control and reload registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            unit_en <= 1'b0;
            pwm_mode <= 1'b0;
            slave_output_enable <= 1'b0;
            slave_output_level <= 1'b0;
            pin_trig_en <= 1'b0;
            master_ch <= `MSP_CH_MASTER_RST;
            slave_ch <= `MSP_CH_SLAVE_RST;
            master_reload_value <= `MSP_RELOAD_RST;
            slave_reload_value <= `MSP_RELOAD_RST;
        end else begin
            if (wr_ctrl) begin
                unit_en <= ctrl_new[`MSP_CTRL_UNIT_EN];
            end
            if (unit_clr) begin
                // see R19
                pwm_mode <= 1'b0;
                slave_output_enable <= 1'b0;
                slave_output_level <= 1'b0;
                pin_trig_en <= 1'b0;
                master_ch <= `MSP_CH_MASTER_RST;
                slave_ch <= `MSP_CH_SLAVE_RST;
                master_reload_value <= `MSP_RELOAD_RST;
                slave_reload_value <= `MSP_RELOAD_RST;
            end else begin
                if (wr_ctrl) begin
                    pwm_mode <= ctrl_new[`MSP_CTRL_PWM];
                    slave_output_enable <= ctrl_new[`MSP_CTRL_OUT_EN];
                    slave_output_level <= ctrl_new[`MSP_CTRL_OUT_LVL];
                    pin_trig_en <= ctrl_new[`MSP_CTRL_PIN_EN];
                    master_ch <= ctrl_new[`MSP_CTRL_MCH_HI:`MSP_CTRL_MCH_LO];
                    slave_ch <= ctrl_new[`MSP_CTRL_SCH_HI:`MSP_CTRL_SCH_LO];
                end
                if (wr_mrel) begin
                    master_reload_value <= mrel_new[`MSP_CNT_W-1:0];
                end
                if (wr_srel) begin
                    slave_reload_value <= srel_new[`MSP_CNT_W-1:0];
                end
            end
        end
    end

    // enable flags
    always @(posedge clk_i) begin
        if (rst_i) begin
            master_enabled_flag <= 1'b0;
            slave_enabled_flag <= 1'b0;
        end else if (unit_clr) begin
            master_enabled_flag <= 1'b0;
            slave_enabled_flag <= 1'b0;
        // a stop wins over a start in the same write
        end else if (sw_stop) begin
            master_enabled_flag <= 1'b0; // see R17
            slave_enabled_flag <= 1'b0; // see R17
        end else begin
            if (sw_start) begin
                master_enabled_flag <= 1'b1; // see R11
            end
            if (sw_start | sw_sstart) begin
                slave_enabled_flag <= 1'b1; // see R11
            end
        end
    end

    // pin-facing outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_bit <= 1'b0;
            pulse_output_o <= 1'b0;
            port_mode_o <= 1'b1;
            master_done_irq_o <= 1'b0;
            slave_done_irq_o <= 1'b0;
        end else begin
            out_bit <= next_out_bit;
            pulse_output_o <= next_out_bit;
            port_mode_o <= unit_clr; // see R19
            master_done_irq_o <= m_done & ~unit_clr; // see R4 see R14
            slave_done_irq_o <= s_done & ~unit_clr; // see R6
        end
    end

    // read mux
    reg [`MSP_DAT_W-1:0] rdat;
    always @* begin
        rdat = `MSP_DAT_ZERO;
        case (adr_i)
            `MSP_ADR_CTRL: rdat = ctrl_word;
            `MSP_ADR_TRIG: rdat = `MSP_DAT_ZERO; // see R11
            `MSP_ADR_MRELOAD: rdat = {16'h0000, master_reload_value};
            `MSP_ADR_SRELOAD: rdat = {16'h0000, slave_reload_value};
            `MSP_ADR_MCOUNT: rdat = {16'h0000, master_counter}; // see R16
            `MSP_ADR_SCOUNT: rdat = {16'h0000, slave_counter}; // see R16
            `MSP_ADR_STATUS: begin
                rdat[`MSP_STAT_MEN] = master_enabled_flag;
                rdat[`MSP_STAT_SEN] = slave_enabled_flag;
                rdat[`MSP_STAT_MRUN] = m_run;
                rdat[`MSP_STAT_SRUN] = s_run;
                rdat[`MSP_STAT_OUT] = out_bit;
                rdat[`MSP_STAT_PORT] = port_mode_o;
            end
            default: rdat = `MSP_DAT_ZERO;
        endcase
    end

    // one wait state, ack for every address, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `MSP_DAT_ZERO;
        end else begin
            ack_o <= req;
            if (req & ~we_i) begin
                dat_o <= rdat;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/msp_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// drives the external trigger line and measures active-high pulses on the load
module msp_pin_model (
    input wire logic clk_i,
    input wire logic pulse_i,
    output logic trig_o
);
    int run = 0;
    int width = 0;
    int n_pulses = 0;
    initial trig_o = 1'b0;
    // the line idles low between triggers, so it is released low
    task automatic fire();
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        if (pulse_i === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            n_pulses <= n_pulses + 1;
            run <= 0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/msp_top_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "msp_defines.vh"
module msp_top_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`MSP_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [`MSP_DAT_W-1:0] dat_i,
    input wire logic [`MSP_DAT_W-1:0] dat_o,
    input wire logic ack_o,
    input wire logic trigger_input_pin_i,
    input wire logic pulse_output_o,
    input wire logic port_mode_o,
    input wire logic master_done_irq_o,
    input wire logic slave_done_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bus_answer: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_trig_reads_zero: assert property ((ack_o && !$past(we_i) && $past(adr_i) == `MSP_ADR_TRIG) |-> dat_o == 32'h0)
        else $error("trigger register read nonzero");
    a_out_cause: assert property ($changed(pulse_output_o)
        |-> (master_done_irq_o || ack_o || $past(ack_o)) or (##1 slave_done_irq_o))
        else $error("output changed without a timer or bus cause");
    a_mdone_single: assert property (master_done_irq_o |=> !master_done_irq_o)
        else $error("master done longer than one cycle");
    a_sdone_single: assert property (slave_done_irq_o |=> !slave_done_irq_o)
        else $error("slave done longer than one cycle");
    a_sdone_after_pulse: assert property (slave_done_irq_o |-> $past(pulse_output_o, 2) != $past(pulse_output_o))
        else $error("slave done not one cycle after pulse end");
    a_port_quiet: assert property (port_mode_o |-> !pulse_output_o && !master_done_irq_o && !slave_done_irq_o)
        else $error("activity while in port mode");
    a_port_by_write: assert property ($changed(port_mode_o) |-> ack_o || $past(ack_o))
        else $error("port mode changed without a bus write");
endmodule
bind msp_top msp_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trigger_input_pin_i(trigger_input_pin_i), .pulse_output_o(pulse_output_o), .port_mode_o(port_mode_o),
    .master_done_irq_o(master_done_irq_o), .slave_done_irq_o(slave_done_irq_o));
`default_nettype wire

// ==== tb/msp_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "msp_defines.vh"
module msp_top_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [`MSP_ADR_W-1:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [`MSP_DAT_W-1:0] dat_i = 32'h00000000;
    wire [`MSP_DAT_W-1:0] dat_o;
    wire ack_o, trig, pulse_o, port_mode_o, mirq, sirq;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    always #4 clk_i = ~clk_i;
    msp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .trigger_input_pin_i(trig),
        .pulse_output_o(pulse_o), .port_mode_o(port_mode_o), .master_done_irq_o(mirq), .slave_done_irq_o(sirq));
    msp_pin_model pin (.clk_i(clk_i), .pulse_i(pulse_o), .trig_o(trig));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // classic single cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, exp, what);
    endtask
    // count from the ack edge until master done is seen; cycle 1 is the ack cycle
    task automatic wait_mdone(output int k);
        k = 1;
        while (mirq !== 1'b1 && k < 300) begin
            @(posedge clk_i);
            k++;
        end
    endtask
    task automatic oneshot(input int m, input int s, input logic lvl);
        int k;
        int j;
        logic act;
        act = ~lvl;
        wr(`MSP_ADR_MRELOAD, m);
        wr(`MSP_ADR_SRELOAD, s);
        wr(`MSP_ADR_TRIG, 32'h3);
        wait_mdone(k);
        check(k, m + 2, "start delay");
        check(pulse_o, act, "pulse active");
        j = 0;
        while (pulse_o === act && j < 300) begin
            @(posedge clk_i);
            j++;
        end
        check(j, s, "pulse width");
        @(posedge clk_i);
        check(sirq, 1'b1, "slave done");
        repeat (10) @(posedge clk_i);
        rd(`MSP_ADR_MCOUNT, 32'h0, "master holds");
        rd(`MSP_ADR_STATUS, {27'h0, lvl, 4'h3}, "flags set");
    endtask
    int pm[7] = '{0, 2, 4, 6, 1, 4, 6};
    int ps[7] = '{1, 3, 7, 7, 2, 4, 5};
    logic [31:0] q;
    logic [31:0] q2;
    logic p;
    int k;
    int n;
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`MSP_ADR_CTRL, 32'h00001000, "ctrl reset");
        rd(`MSP_ADR_STATUS, 32'h00000020, "status reset");
        rd(8'h1C, 32'h0, "unmapped");
        check(port_mode_o, 1'b1, "port mode");
        $display("test reset done");
        wr(`MSP_ADR_CTRL, 32'h00000001);
        wr(`MSP_ADR_CTRL, 32'h00001005);
        oneshot(3, 4, 1'b0);
        oneshot(0, 1, 1'b0);
        wr(`MSP_ADR_CTRL, 32'h00001019);
        wr(`MSP_ADR_CTRL, 32'h00001015);
        oneshot(2, 3, 1'b1);
        rd(`MSP_ADR_TRIG, 32'h0, "trigger auto clear");
        $display("test oneshot done");
        wr(`MSP_ADR_CTRL, 32'h00001001);
        wr(`MSP_ADR_CTRL, 32'h00001025);
        n = pin.n_pulses;
        pin.fire();
        repeat (30) @(posedge clk_i);
        check(pin.n_pulses, n + 1, "pin pulse count");
        check(pin.width, 3, "pin pulse width");
        $display("test pin trigger done");
        wr(`MSP_ADR_CTRL, 32'h00001007);
        wr(`MSP_ADR_MRELOAD, 32'h4);
        wr(`MSP_ADR_SRELOAD, 32'h2);
        wr(`MSP_ADR_TRIG, 32'h3);
        wait_mdone(k);
        check(k <= 3, 1'b1, "pwm first done");
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (mirq !== 1'b1 && k < 300);
        check(k, 5, "pwm period");
        repeat (12) @(posedge clk_i);
        check(pin.width, 2, "pwm duty");
        wb(1'b0, `MSP_ADR_MCOUNT, 32'h0, q);
        check(q <= 4, 1'b1, "count readable");
        wr(`MSP_ADR_TRIG, 32'hC);
        rd(`MSP_ADR_STATUS, {26'h0, 1'b0, pulse_o, 4'h0}, "flags clear");
        p = pulse_o;
        wb(1'b0, `MSP_ADR_MCOUNT, 32'h0, q);
        repeat (10) @(posedge clk_i);
        wb(1'b0, `MSP_ADR_MCOUNT, 32'h0, q2);
        check(q2, q, "count frozen");
        check(pulse_o, p, "output held");
        $display("test pwm done");
        wr(`MSP_ADR_CTRL, 32'h00001009);
        repeat (3) @(posedge clk_i);
        check(pulse_o, 1'b1, "output bit high");
        wr(`MSP_ADR_CTRL, 32'h00001001);
        repeat (3) @(posedge clk_i);
        check(pulse_o, 1'b0, "output bit low");
        wr(`MSP_ADR_MRELOAD, 32'h64);
        for (int i = 0; i < 7; i++) begin
            wr(`MSP_ADR_CTRL, 32'h5 | (pm[i] << 8) | (ps[i] << 12));
            wr(`MSP_ADR_TRIG, 32'h3);
            wb(1'b0, `MSP_ADR_STATUS, 32'h0, q);
            check(q[0], i < 4, "channel pair");
            wr(`MSP_ADR_TRIG, 32'hC);
        end
        $display("test channels done");
        wr(`MSP_ADR_CTRL, 32'h0);
        wr(`MSP_ADR_TRIG, 32'h3);
        check(port_mode_o, 1'b1, "port mode again");
        rd(`MSP_ADR_MRELOAD, 32'h0, "reload cleared");
        rd(`MSP_ADR_STATUS, 32'h00000020, "unit off");
        $display("test unit disable done");
        report_and_stop();
    end
endmodule
`default_nettype wire
